// ---- pil_port_io.v ----
`include "pil_regs.vh"
`default_nettype none
// Functional notes
// - kill bit clear keeps pull-ups on, except analog/actively driving push-pull/open-drain driving low
// - unrouted digital pins act as plain port pins
// - ports 0-3 byte and bit access; port 4 byte
// - writes go to latch, held until rewritten
// - ordinary read returns live pin levels
// - read-modify-write reads the latch, not pins
// - matrix enable off disables ports 0-3 drivers
// - open-drain pull-up off while driving low
// - bus data/clock pins always open-drain
// - input kind 1 digital, 0 analog; reset digital
module pil_port_io (
  input  wire        clk_in,
  input  wire        resetn_in,
  input  wire [7:0]  sfr_addr_in,
  input  wire [7:0]  sfr_wdata_in,
  input  wire        sfr_wr_in,
  input  wire        sfr_rd_in,
  input  wire        sfr_rmw_in,
  input  wire        sfr_bit_wr_in,
  input  wire [2:0]  sfr_bit_sel_in,
  input  wire        sfr_bit_val_in,
  output reg  [7:0]  sfr_rdata_out,
  output reg         sfr_hit_out,
  input  wire [39:0] pin_in,
  input  wire [39:0] route_sel_in,
  input  wire [39:0] route_data_in,
  input  wire [39:0] smbus_pin_in,
  output wire [39:0] pin_out,
  output wire [39:0] pin_oe_out,
  output wire [39:0] pullup_out
);
  // ==================================================
  // address tables
  function [7:0] latch_addr;
    input integer idx;
    case (idx)
      0:       latch_addr = `PIL_ADDR_LATCH0;
      1:       latch_addr = `PIL_ADDR_LATCH1;
      2:       latch_addr = `PIL_ADDR_LATCH2;
      3:       latch_addr = `PIL_ADDR_LATCH3;
      default: latch_addr = `PIL_ADDR_LATCH4;
    endcase
  endfunction

  function [7:0] mdout_addr;
    input integer idx;
    case (idx)
      0:       mdout_addr = `PIL_ADDR_MDOUT0;
      1:       mdout_addr = `PIL_ADDR_MDOUT1;
      2:       mdout_addr = `PIL_ADDR_MDOUT2;
      3:       mdout_addr = `PIL_ADDR_MDOUT3;
      default: mdout_addr = `PIL_ADDR_MDOUT4;
    endcase
  endfunction

  function [7:0] mdin_addr;
    input integer idx;
    case (idx)
      0:       mdin_addr = `PIL_ADDR_MDIN0;
      1:       mdin_addr = `PIL_ADDR_MDIN1;
      2:       mdin_addr = `PIL_ADDR_MDIN2;
      3:       mdin_addr = `PIL_ADDR_MDIN3;
      default: mdin_addr = `PIL_ADDR_MDIN4;
    endcase
  endfunction

  // ==================================================
  // state
  wire [39:0] latch_all;
  wire [39:0] mdout_all;
  wire [39:0] mdin_all;
  reg  [7:0]  route_b_q;
  reg  [39:0] pin_meta_q;
  reg  [39:0] pin_sync_q;
  wire        pullup_kill;
  wire        matrix_enable;
  wire [39:0] pin_level;

  assign pullup_kill   = route_b_q[`PIL_BIT_PULLUP_KILL];
  assign matrix_enable = route_b_q[`PIL_BIT_MATRIX_ENABLE];
  // analog pins read as zero
  assign pin_level     = pin_sync_q & mdin_all;

  // ==================================================
  // pin input synchroniser
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      pin_meta_q <= 40'h00_0000_0000;
      pin_sync_q <= 40'h00_0000_0000;
    end else begin
      pin_meta_q <= pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ==================================================
  // routing control register
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      route_b_q <= `PIL_RST_ROUTE_B;
    end else if (sfr_wr_in && sfr_addr_in == `PIL_ADDR_ROUTE_B) begin
      route_b_q <= sfr_wdata_in;
    end
  end

  // ==================================================
  // per-port registers and pin cells
  genvar p;
  genvar b;
  generate
    for (p = 0; p < `PIL_PORTS; p = p + 1) begin : g_port
      wire       lat_sel;
      wire       mdo_sel;
      wire       mdi_sel;
      wire       bit_ok;
      wire       drv_on;
      reg  [7:0] lat_q;
      reg  [7:0] lat_d;
      reg  [7:0] mdo_q;
      reg  [7:0] mdo_d;
      reg  [7:0] mdi_q;
      reg  [7:0] mdi_d;
      assign lat_sel = (sfr_addr_in == latch_addr(p));
      assign mdo_sel = (sfr_addr_in == mdout_addr(p));
      assign mdi_sel = (sfr_addr_in == mdin_addr(p));
      assign bit_ok  = (p < `PIL_BIT_PORTS);
      assign drv_on  = bit_ok ? matrix_enable : 1'b1;

      // next values: a byte write wins over a bit write
      always @* begin
        lat_d = lat_q;
        mdo_d = mdo_q;
        mdi_d = mdi_q;
        if (sfr_wr_in && lat_sel) begin
          lat_d = sfr_wdata_in;
        end else if (sfr_bit_wr_in && lat_sel && bit_ok) begin
          lat_d[sfr_bit_sel_in] = sfr_bit_val_in;
        end
        if (sfr_wr_in && mdo_sel) begin
          mdo_d = sfr_wdata_in;
        end
        if (sfr_wr_in && mdi_sel) begin
          mdi_d = sfr_wdata_in;
        end
      end

      always @(posedge clk_in) begin
        if (!resetn_in) begin
          lat_q <= `PIL_RST_LATCH;
          mdo_q <= `PIL_RST_MDOUT;
          mdi_q <= `PIL_RST_MDIN;
        end else begin
          lat_q <= lat_d;
          mdo_q <= mdo_d;
          mdi_q <= mdi_d;
        end
      end

      assign latch_all[p*8 +: 8] = lat_q;
      assign mdout_all[p*8 +: 8] = mdo_q;
      assign mdin_all[p*8 +: 8]  = mdi_q;

      for (b = 0; b < 8; b = b + 1) begin : g_pin
        pil_pin_cell u_cell (
          .latch_in       (lat_q[b]),
          .push_pull_in   (mdo_q[b]),
          .digital_in     (mdi_q[b]),
          .pullup_kill_in (pullup_kill),
          .drivers_on_in  (drv_on),
          .route_sel_in   ((p < `PIL_BIT_PORTS) ? route_sel_in[p*8+b] : 1'b0),
          .route_data_in  (route_data_in[p*8+b]),
          .smbus_in       (smbus_pin_in[p*8+b]),
          .pin_out        (pin_out[p*8+b]),
          .pin_oe_out     (pin_oe_out[p*8+b]),
          .pullup_out     (pullup_out[p*8+b])
        );
      end
    end
  endgenerate

  // ==================================================
  // read path
  reg [7:0] rd_d;
  reg       hit_d;
  integer   i;
  always @* begin
    rd_d  = 8'h00;
    hit_d = 1'b0;
    if (sfr_addr_in == `PIL_ADDR_ROUTE_B) begin
      rd_d  = route_b_q;
      hit_d = 1'b1;
    end
    for (i = 0; i < `PIL_PORTS; i = i + 1) begin
      if (sfr_addr_in == latch_addr(i)) begin
        rd_d  = sfr_rmw_in ? latch_all[i*8 +: 8] : pin_level[i*8 +: 8];
        hit_d = 1'b1;
      end
      if (sfr_addr_in == mdout_addr(i)) begin
        rd_d  = mdout_all[i*8 +: 8];
        hit_d = 1'b1;
      end
      if (sfr_addr_in == mdin_addr(i)) begin
        rd_d  = mdin_all[i*8 +: 8];
        hit_d = 1'b1;
      end
    end
  end

  always @(posedge clk_in) begin
    if (!resetn_in) begin
      sfr_rdata_out <= 8'h00;
      sfr_hit_out   <= 1'b0;
    end else if (sfr_rd_in) begin
      sfr_rdata_out <= rd_d;
      sfr_hit_out   <= hit_d;
    end else begin
      sfr_hit_out   <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- pil_regs.vh ----
`ifndef PIL_REGS_VH
`define PIL_REGS_VH
// ==================================================
// register addresses in the special-function space
`define PIL_ADDR_LATCH0   8'h80
`define PIL_ADDR_LATCH1   8'h90
`define PIL_ADDR_LATCH2   8'hA0
`define PIL_ADDR_LATCH3   8'hB0
`define PIL_ADDR_LATCH4   8'hC7
`define PIL_ADDR_MDOUT0   8'hA4
`define PIL_ADDR_MDOUT1   8'hA5
`define PIL_ADDR_MDOUT2   8'hA6
`define PIL_ADDR_MDOUT3   8'hA7
`define PIL_ADDR_MDOUT4   8'hAE
`define PIL_ADDR_MDIN0    8'hF1
`define PIL_ADDR_MDIN1    8'hF2
`define PIL_ADDR_MDIN2    8'hF3
`define PIL_ADDR_MDIN3    8'hF4
`define PIL_ADDR_MDIN4    8'hF5
`define PIL_ADDR_ROUTE_B  8'hE2
// ==================================================
// field positions
`define PIL_BIT_PULLUP_KILL   7
`define PIL_BIT_MATRIX_ENABLE 6
// ==================================================
// reset values
`define PIL_RST_LATCH   8'hFF
`define PIL_RST_MDOUT   8'h00
`define PIL_RST_MDIN    8'hFF
`define PIL_RST_ROUTE_B 8'h00
// ==================================================
// sizes
`define PIL_PORTS       5
`define PIL_PINS        40
`define PIL_BIT_PORTS   4
`endif

// ---- pil_pin_cell.v ----
`default_nettype none
// ==================================================
// per-pin driver and pull-up control
module pil_pin_cell (
  input  wire latch_in,
  input  wire push_pull_in,
  input  wire digital_in,
  input  wire pullup_kill_in,
  input  wire drivers_on_in,
  input  wire route_sel_in,
  input  wire route_data_in,
  input  wire smbus_in,
  output wire pin_out,
  output wire pin_oe_out,
  output wire pullup_out
);
  wire value;
  wire open_drain;
  wire drive_ok;
  wire pp_active;

  assign value      = route_sel_in ? route_data_in : latch_in;
  assign open_drain = ~push_pull_in | smbus_in;
  assign drive_ok   = drivers_on_in & digital_in;
  assign pin_oe_out = drive_ok & (open_drain ? ~value : 1'b1);
  assign pin_out    = drive_ok & ~open_drain & value;
  assign pp_active  = drive_ok & ~open_drain;
  assign pullup_out = digital_in & ~pullup_kill_in & ~pp_active
                      & ~(drive_ok & open_drain & ~value);
endmodule
`default_nettype wire

// ---- pil_pad_model.sv ----
`default_nettype none
module pil_pad_model (
  input  wire logic        clk_in,
  input  wire logic [39:0] drv_in,
  input  wire logic [39:0] oe_in,
  input  wire logic [39:0] pu_in,
  input  wire logic [39:0] ext_en_in,
  input  wire logic [39:0] ext_in,
  output var  logic [39:0] lvl_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ======
  // pads: driven, external, pulled up, else a changing level
  logic flip_q = 1'b0;
  always @(posedge clk_in) flip_q <= ~flip_q;
  assign lvl_out = (oe_in & drv_in) | (~oe_in & ext_en_in & ext_in)
    | (~oe_in & ~ext_en_in & (pu_in | {40{flip_q}}));
endmodule
`default_nettype wire

// ---- pil_port_io_assertions.sv ----
`default_nettype none
module pil_port_io_assertions (
  input wire logic        clk_in,
  input wire logic        resetn_in,
  input wire logic [7:0]  sfr_addr_in,
  input wire logic [7:0]  sfr_wdata_in,
  input wire logic        sfr_wr_in,
  input wire logic        sfr_rd_in,
  input wire logic        sfr_rmw_in,
  input wire logic        sfr_bit_wr_in,
  input wire logic [7:0]  sfr_rdata_out,
  input wire logic        sfr_hit_out,
  input wire logic [39:0] smbus_pin_in,
  input wire logic [39:0] pin_out,
  input wire logic [39:0] pin_oe_out,
  input wire logic [39:0] pullup_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // ======
  // properties
  property p_rst; disable iff (1'b0) !resetn_in |=> pin_oe_out == 40'h00_0000_0000 && &pullup_out; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_od; (pullup_out & pin_oe_out & ~pin_out) == 40'h00_0000_0000; endproperty
  a_od: assert property (p_od) else $error("pull-up on while driving low");
  property p_smb; (smbus_pin_in & pin_oe_out & pin_out) == 40'h00_0000_0000; endproperty
  a_smb: assert property (p_smb) else $error("bus pin driven high");
  property p_rd; sfr_rd_in && !sfr_rmw_in && sfr_addr_in == 8'h80 |=> sfr_hit_out; endproperty
  a_rd: assert property (p_rd) else $error("port read not answered");
  property p_unm; sfr_rd_in && sfr_addr_in == 8'h00 |=> !sfr_hit_out && sfr_rdata_out == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read answered");
  property p_hit; sfr_hit_out |-> $past(sfr_rd_in); endproperty
  a_hit: assert property (p_hit) else $error("hit without read");
  property p_rmw; sfr_wr_in && sfr_addr_in == 8'h80 ##1 !sfr_wr_in && !sfr_bit_wr_in
    ##1 sfr_rd_in && sfr_rmw_in && sfr_addr_in == 8'h80 |=> sfr_rdata_out == $past(sfr_wdata_in, 3); endproperty
  a_rmw: assert property (p_rmw) else $error("latch read wrong");
  property p_mx; sfr_wr_in && sfr_addr_in == 8'hE2 && !sfr_wdata_in[6] |=> pin_oe_out[31:0] == 32'h0000_0000;
  endproperty
  a_mx: assert property (p_mx) else $error("drivers on with matrix off");
  c_rd: cover property (sfr_hit_out);
  c_oe: cover property (|pin_oe_out);
  c_rmw: cover property (sfr_rd_in && sfr_rmw_in);
endmodule
bind pil_port_io pil_port_io_assertions pil_port_io_assertions_i (
  .clk_in        (clk_in),
  .resetn_in     (resetn_in),
  .sfr_addr_in   (sfr_addr_in),
  .sfr_wdata_in  (sfr_wdata_in),
  .sfr_wr_in     (sfr_wr_in),
  .sfr_rd_in     (sfr_rd_in),
  .sfr_rmw_in    (sfr_rmw_in),
  .sfr_bit_wr_in (sfr_bit_wr_in),
  .sfr_rdata_out (sfr_rdata_out),
  .sfr_hit_out   (sfr_hit_out),
  .smbus_pin_in  (smbus_pin_in),
  .pin_out       (pin_out),
  .pin_oe_out    (pin_oe_out),
  .pullup_out    (pullup_out)
);
`default_nettype wire

// ---- tb_top.sv ----
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("wrong value %0t: got %0h, expected %0h", $time, (a), (b)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_in = 0, resetn_in = 0, wr = 0, rd = 0, rmw = 0, bw = 0, bv = 0, hit;
  logic [7:0]  ad = 0, wd = 0, rdat;
  logic [2:0]  bs = 0;
  logic [39:0] pin, sel = 0, rdt = 0, smb = 0, po, oe, pu, een = 0, ext = 0;
  int          n_errors = 0, num_checks = 0;
  pil_port_io pil_port_io_i (.clk_in(clk_in), .resetn_in(resetn_in), .sfr_addr_in(ad), .sfr_wdata_in(wd),
    .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_rmw_in(rmw), .sfr_bit_wr_in(bw), .sfr_bit_sel_in(bs),
    .sfr_bit_val_in(bv), .sfr_rdata_out(rdat), .sfr_hit_out(hit), .pin_in(pin), .route_sel_in(sel),
    .route_data_in(rdt), .smbus_pin_in(smb), .pin_out(po), .pin_oe_out(oe), .pullup_out(pu));
  pil_pad_model pil_pad_model_i (.clk_in(clk_in), .drv_in(po), .oe_in(oe), .pu_in(pu), .ext_en_in(een),
    .ext_in(ext), .lvl_out(pin));
  // ======
  // access tasks
  initial forever #5 clk_in = ~clk_in;
  task automatic wrb(input logic [7:0] a, d);
    @(posedge clk_in) #1 {wr, ad, wd} = {1'b1, a, d};
    @(posedge clk_in) #1 wr = 0;
  endtask
  task automatic bwr(input logic [7:0] a, input logic [2:0] s, input logic v);
    @(posedge clk_in) #1 {bw, ad, bs, bv} = {1'b1, a, s, v};
    @(posedge clk_in) #1 bw = 0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic m, input logic [7:0] e);
    @(posedge clk_in) #1 {rd, rmw, ad} = {1'b1, m, a};
    @(posedge clk_in) #1 {rd, rmw} = 2'b00;
    `CHK(rdat, e)
    `CHK(hit, a != 8'h00)
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    close_out();
  end
  // ======
  // tests
  initial begin
    repeat (5) @(posedge clk_in);
    #1 resetn_in = 1;
    rdc(8'h80, 1, 8'hFF);
    rdc(8'hA4, 0, 8'h00);
    rdc(8'hE2, 0, 8'h00);
    rdc(8'h00, 0, 8'h00);
    `CHK(pu, {40{1'b1}})
    wrb(8'h80, 8'h00);
    `CHK(oe[31:0], 32'h0000_0000)
    rdc(8'h80, 1, 8'h00);
    rdc(8'h80, 0, 8'hFF);
    wrb(8'hE2, 8'h40);
    `CHK({oe[7:0], po[7:0], pu[7:0]}, 24'hFF_0000)
    wrb(8'hA4, 8'hFF);
    wrb(8'h80, 8'h5A);
    `CHK({oe[7:0], po[7:0], pu[7:0]}, 24'hFF_5A00)
    repeat (2) @(posedge clk_in);
    rdc(8'h80, 0, 8'h5A);
    bwr(8'h80, 3'd0, 1);
    rdc(8'h80, 1, 8'h5B);
    bwr(8'hC7, 3'd0, 0);
    rdc(8'hC7, 1, 8'hFF);
    sel[7] = 1;
    rdt[7] = 1;
    repeat (3) @(posedge clk_in);
    rdc(8'h80, 0, 8'hDB);
    rdc(8'h80, 1, 8'h5B);
    wrb(8'hA4, 8'h00);
    wrb(8'h80, 8'hFF);
    `CHK(pu[7:0], 8'hFF)
    wrb(8'hE2, 8'hC0);
    `CHK(pu, 40'h00_0000_0000)
    smb[0] = 1;
    wrb(8'hA4, 8'hFF);
    `CHK(oe[1:0], 2'b10)
    smb[0] = 0;
    wrb(8'hF1, 8'hFE);
    `CHK(oe[1:0], 2'b10)
    rdc(8'h80, 0, 8'hFE);
    wrb(8'hE2, 8'h00);
    wrb(8'hAE, 8'h01);
    `CHK(oe[32:0], 33'h1_0000_0000)
    close_out();
  end
endmodule
`default_nettype wire
